// ---- common/ecc_stat_defines.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   definitions only
`ifndef ECC_STAT_DEFINES_SVH
`define ECC_STAT_DEFINES_SVH

// error count registers
`define ADDR_RETRY_ECC_COUNT  12'h0038
`define ADDR_RESP_ECC_COUNT   12'h003C
// interrupt status (write one to clear) and mask registers
`define ADDR_IRQ_STATUS       12'h0040
`define ADDR_IRQ_MASK         12'h0044

`define UNCORR_MSB            23
`define UNCORR_LSB            16
`define CORR_MSB              7
`define CORR_LSB              0
`define COUNT_RESET           8'h00
`define COUNT_SAT             8'hFF
`define IRQ_RESET             4'h0

// interrupt status bit positions
`define IRQ_RETRY_CORR        0
`define IRQ_RETRY_UNCORR      1
`define IRQ_RESP_CORR         2
`define IRQ_RESP_UNCORR       3

// apb answers in the access cycle with no wait state
`define APB_WAIT_CYCLES       0

`endif

// ---- common/ecc_stat_pkg.sv ----
// Purpose: shared types for the ecc error statistics block
// Assumes: nothing beyond the defines header
// Notes:   no constants here, only types
package ecc_stat_pkg;

  // one error report from a memory's ecc decoder
  typedef struct packed {
    logic corr;   // single-bit error found and corrected
    logic uncorr; // multi-bit error found, not correctable
  } ecc_event_t;

  // apb request fields
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  // bus side state of the slave
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ACCESS = 2'b10
  } bus_state_t;

endpackage

// ---- sim/ecc_error_stat_counters_asserts.sv ----
// Purpose: port-level checks on the ecc statistics block
// Assumes: one pclk domain, presetn async active low
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
module ecc_error_stat_counters_asserts (
  input wire logic pclk, presetn, psel, penable, pwrite, // bus controls
  input wire logic pready, pslverr, ecc_enable, irq,     // status lines
  input wire logic [11:0] paddr,                         // byte address
  input wire logic [31:0] prdata,                        // read data
  input wire ecc_stat_pkg::ecc_event_t retry_err         // retry events
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decode helpers; quiet means no retry event in that cycle
  wire logic mp = paddr inside {12'h038, 12'h03C, 12'h040, 12'h044};
  wire logic rd38 = psel && !penable && !pwrite && paddr == 12'h038;
  wire logic acc = psel && penable;
  wire logic q = retry_err == 2'b00;
  sequence plain_rd; rd38 && q ##1 acc && q ##1 !psel && q; endsequence
  sequence race_rd;
    rd38 && q ##1 acc && retry_err == 2'b10 ##1 !psel && q;
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_rsvd_zero: assert property (
    prdata[31:24] == 0 && prdata[15:8] == 0) else $error("reserved set");
  chk_unmapped_err: assert property (acc && !mp |-> pslverr)
    else $error("no slverr");
  chk_mapped_ok: assert property (acc && mp |-> !pslverr)
    else $error("bad slverr");
  chk_unmapped_data: assert property (
    psel && !penable && !pwrite && !mp |=> prdata == 0)
    else $error("unmapped data");
  chk_off_zero: assert property (
    !ecc_enable [*2] ##0 rd38 |=> prdata == 0) else $error("counted off");
  chk_read_clear: assert property (
    plain_rd ##1 rd38 && q |=> prdata == 0) else $error("not cleared");
  chk_event_kept: assert property (
    race_rd ##1 rd38 && q |=> prdata == 32'h0000_0001)
    else $error("event lost");
  chk_irq_quiet: assert property (!$past(presetn) |-> !irq)
    else $error("irq after reset");
endmodule // ecc_error_stat_counters_asserts

bind ecc_error_stat_counters ecc_error_stat_counters_asserts chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .irq(irq),
  .ecc_enable(ecc_enable), .paddr(paddr), .prdata(prdata),
  .retry_err(retry_err));

// ---- sim/ecc_error_stat_counters_test.sv ----
// Purpose: self-checking bench for the ecc statistics block
// Assumes: apb slave may add wait states; bench waits bounded
// Notes:   one task per scenario
`timescale 1ns/1ns
module ecc_error_stat_counters_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ecc_enable = 1, pready, pslverr, irq, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  ecc_stat_pkg::ecc_event_t retry_err = 0, resp_err = 0;
  int mismatches = 0, n_checks = 0;
  ecc_error_stat_counters dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .ecc_enable(ecc_enable), .retry_err(retry_err), .resp_err(resp_err));
  // 50 mhz clock
  always #10 pclk = ~pclk;
  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] got, logic [31:0] x);
    n_checks++;
    if (got !== x) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", s, x, got);
    end
  endtask
  // one transfer; ev pulses retry events in the first access cycle
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [1:0] ev);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    retry_err <= ev;
    n = 0;
    do begin
      @(posedge pclk);
      retry_err <= 0;
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x);
    apb(0, a, 0, 0);
    chk($sformatf("read %h", a), r, x);
  endtask
  task automatic pulse(logic [1:0] a, logic [1:0] b, int n);
    repeat (n) begin
      retry_err <= a;
      resp_err <= b;
      @(posedge pclk);
    end
    retry_err <= 0;
    resp_err <= 0;
    @(posedge pclk);
  endtask
  task automatic t_count;
    pulse(2'b11, 2'b00, 2);
    pulse(2'b10, 2'b01, 1);
    pulse(2'b00, 2'b10, 4);
    rd(12'h038, 32'h0002_0003);
    rd(12'h03C, 32'h0001_0004);
    rd(12'h038, 0);
    rd(12'h03C, 0);
  endtask
  task automatic t_sat;
    pulse(2'b11, 2'b11, 260);
    rd(12'h038, 32'h00FF_00FF);
    rd(12'h038, 0);
    rd(12'h03C, 32'h00FF_00FF);
  endtask
  // write to a count register is ignored, then an event lands in the access cycle after the clear
  task automatic t_race;
    apb(1, 12'h038, 32'hFFFF_FFFF, 2'b00);
    apb(0, 12'h038, 0, 2'b10);
    chk("race old", r, 0);
    rd(12'h038, 32'h0000_0001);
  endtask
  task automatic t_off;
    ecc_enable <= 0;
    pulse(2'b11, 2'b11, 3);
    rd(12'h038, 0);
    rd(12'h03C, 0);
    ecc_enable <= 1;
  endtask
  task automatic t_irq;
    apb(1, 12'h040, 32'h0000_000F, 2'b00);
    rd(12'h040, 0);
    pulse(2'b10, 2'b00, 1);
    rd(12'h040, 32'h0000_0001);
    chk("irq masked", irq, 0);
    apb(1, 12'h044, 32'h0000_0001, 2'b00);
    chk("irq on", irq, 1);
    apb(1, 12'h040, 32'h0000_0001, 2'b00);
    chk("irq off", irq, 0);
    apb(0, 12'h050, 0, 2'b00);
    chk("slverr", e, 1);
    chk("unmapped", r, 0);
  endtask
  // reset, then scenarios in turn
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(12'h038, 0);
    rd(12'h03C, 0);
    t_count;
    t_sat;
    t_race;
    t_off;
    t_irq;
    wrap_up();
  end
endmodule // ecc_error_stat_counters_test

// ---- src/ecc_error_stat_counters.sv ----
// Purpose: clear-on-read ecc error statistics counters with an apb slave
// Assumes: error strobes are one-cycle pulses synchronous to pclk
// Notes:   counters stay zero while ecc_enable is low
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`include "ecc_stat_defines.svh"

module ecc_error_stat_counters (
  input  wire logic                    pclk,        // 50 MHz clock
  input  wire logic                    presetn,     // async reset, low
  input  wire logic                    psel,        // apb select
  input  wire logic                    penable,     // apb access phase
  input  wire logic                    pwrite,      // apb direction
  input  wire logic [11:0]             paddr,       // apb byte address
  input  wire logic [31:0]             pwdata,      // apb write data
  output logic      [31:0]             prdata,      // apb read data
  output logic                         pready,      // apb ready
  output logic                         pslverr,     // apb error
  input  wire logic                    ecc_enable,  // run-time ecc enable input
  input  wire ecc_stat_pkg::ecc_event_t retry_err,  // retry buffer events
  input  wire ecc_stat_pkg::ecc_event_t resp_err,   // response queue events
  output logic                         irq          // level interrupt
);

  ecc_stat_pkg::apb_req_t   req;
  ecc_stat_pkg::bus_state_t bus_state;
  logic [7:0] retry_corr;
  logic [7:0] retry_uncorr;
  logic [7:0] resp_corr;
  logic [7:0] resp_uncorr;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic       access;
  logic       rd_retry;
  logic       rd_resp;
  logic       wr_status;
  logic       wr_mask;
  logic       mapped;
  logic [31:0] next_prdata;

  // next counter value: clear on read, count an event, saturate
  function automatic logic [7:0] count_next(input logic [7:0] cur,
                                             input logic       ev,
                                             input logic       clr,
                                             input logic       en);
    logic [7:0] res;
    res = cur;
    if (!en) begin
      res = `COUNT_RESET;
    end else if (clr) begin
      // the event is kept: the read saw the old value, one remains
      res = ev ? 8'h01 : `COUNT_RESET;
    end else if (ev && cur != `COUNT_SAT) begin
      res = cur + 8'h01;
    end
    return res;
  endfunction

  // pack both fields of a count register, reserved bits zero
  function automatic logic [31:0] pack_count(input logic [7:0] unc,
                                              input logic [7:0] cor);
    logic [31:0] word;
    word = 32'h0000_0000;
    word[`UNCORR_MSB:`UNCORR_LSB] = unc;
    word[`CORR_MSB:`CORR_LSB]     = cor;
    return word;
  endfunction

  assign req.sel    = psel;
  assign req.enable = penable;
  assign req.write  = pwrite;
  assign req.addr   = paddr;
  assign req.wdata  = pwdata;

  // decode; a transfer completes in its first access cycle
  // count reads clear at the setup edge, the same edge that captures
  // prdata, so an event landing between capture and clear is not lost
  assign access    = req.sel && req.enable;
  assign rd_retry  = req.sel && !req.enable && !req.write
                     && req.addr == `ADDR_RETRY_ECC_COUNT;
  assign rd_resp   = req.sel && !req.enable && !req.write
                     && req.addr == `ADDR_RESP_ECC_COUNT;
  assign wr_status = access && req.write && req.addr == `ADDR_IRQ_STATUS;
  assign wr_mask   = access && req.write && req.addr == `ADDR_IRQ_MASK;
  assign mapped    = req.addr == `ADDR_RETRY_ECC_COUNT
                     || req.addr == `ADDR_RESP_ECC_COUNT
                     || req.addr == `ADDR_IRQ_STATUS
                     || req.addr == `ADDR_IRQ_MASK;
  assign pready    = 1'b1;
  assign pslverr   = access && !mapped;

  // bus phase tracking, kept for visibility of setup versus access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= ecc_stat_pkg::BUS_IDLE;
    end else begin
      unique case (bus_state)
        ecc_stat_pkg::BUS_IDLE: begin
          if (req.sel && !req.enable) begin
            bus_state <= ecc_stat_pkg::BUS_ACCESS;
          end
        end
        ecc_stat_pkg::BUS_ACCESS: begin
          if (!(req.sel && !req.enable)) begin
            bus_state <= ecc_stat_pkg::BUS_IDLE;
          end
        end
      endcase
    end
  end

  // retry buffer counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_uncorr <= `COUNT_RESET;
      retry_corr   <= `COUNT_RESET;
    end else begin
      retry_uncorr <= count_next(retry_uncorr, retry_err.uncorr,
                                 rd_retry, ecc_enable);
      retry_corr   <= count_next(retry_corr, retry_err.corr,
                                 rd_retry, ecc_enable);
    end
  end

  // response queue counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_uncorr <= `COUNT_RESET;
      resp_corr   <= `COUNT_RESET;
    end else begin
      resp_uncorr <= count_next(resp_uncorr, resp_err.uncorr,
                                rd_resp, ecc_enable);
      resp_corr   <= count_next(resp_corr, resp_err.corr,
                                rd_resp, ecc_enable);
    end
  end

  // sticky event flags; a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~(wr_status ? req.wdata[3:0] : 4'h0))
                    | ({4{ecc_enable}}
                       & {resp_err.uncorr, resp_err.corr,
                          retry_err.uncorr, retry_err.corr});
    end
  end

  // interrupt mask, one bit per status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask <= req.wdata[3:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read data mux; registered so prdata comes from a flip-flop
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (req.sel && !req.enable && !req.write) begin
      unique case (req.addr)
        `ADDR_RETRY_ECC_COUNT:
          next_prdata = pack_count(retry_uncorr, retry_corr);
        `ADDR_RESP_ECC_COUNT:
          next_prdata = pack_count(resp_uncorr, resp_corr);
        `ADDR_IRQ_STATUS: next_prdata = {28'h000_0000, irq_status};
        `ADDR_IRQ_MASK:   next_prdata = {28'h000_0000, irq_mask};
        default:          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // capture in setup, together with the clear; an event at that edge
  // is kept in the counter as one and reported by the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (req.sel && !req.enable) begin
      prdata <= next_prdata;
    end
  end

endmodule // ecc_error_stat_counters
